// >>> rtl/tms_regs.vh
// register map, field positions, reset values and timing constants of the scheduler
`ifndef TMS_REGS_VH
`define TMS_REGS_VH
`define TMS_A_CTRL 8'h00
`define TMS_A_SLOT_START 8'h04
`define TMS_A_SLOT_DUR 8'h08
`define TMS_A_FRAME_DUR 8'h0c
`define TMS_A_GUARD 8'h10
`define TMS_A_STATUS 8'h14
`define TMS_A_FRAME_CNT 8'h18
`define TMS_A_MS_IN_FRAME 8'h1c
`define TMS_A_ACCUM 8'h20
`define TMS_A_RAW 8'h24
`define TMS_A_FIN 8'h28
`define TMS_A_SLOPE 8'h2c
`define TMS_A_OFFS 8'h30
`define TMS_A_INCR 8'h34
`define TMS_A_SNOOP 8'h38
`define TMS_A_CH_BASE 8'h40
`define TMS_B_EN 0
`define TMS_B_LISTEN 1
`define TMS_B_LEARN 2
`define TMS_B_INC_FRAC 3
`define TMS_B_DTYPE16 4
`define TMS_B_RANDOM 0
`define TMS_B_BUS_BUSY 1
`define TMS_B_ADC_BUSY 2
`define TMS_B_SYNCED 3
`define TMS_R_FRAME_DUR 32'h0001d4c0
`define TMS_R_SLOT_DUR 32'h000003e8
`define TMS_R_GUARD 32'h00000019
`define TMS_R_SLOPE 32'h00010000
`define TMS_R_INCR 32'h00000001
`define TMS_K_VOLT 3'h0
`define TMS_K_CURR 3'h1
`define TMS_K_PULSE 3'h2
`define TMS_K_CMD_M 3'h3
`define TMS_K_CMD_C 3'h4
`define TMS_K_CMD_R 3'h5
`define TMS_CLK_KHZ 200000
`define TMS_CYC_PER_MS (`TMS_CLK_KHZ / 1000)
`define TMS_LOCKOUT_MS 50
`define TMS_AVG_MS 13
`define TMS_DRIFT_PPM 2
`define TMS_SYNC_TRIES 4
`define TMS_SENSE_OHM 250
`define TMS_FULL_MV 5000
`define TMS_ADC_MAX 16383
`define TMS_MARGIN_MS 32'h000003e8
`endif

// >>> rtl/tms_top.v
// frame scheduler with averaging front end, pulse accumulator and sensor bus ordering
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "tms_regs.vh"
module tms_top #(
	parameter NCH = 4,
	parameter CHW = 2,
	parameter CYC_PER_MS = `TMS_CYC_PER_MS,
	parameter LOCKOUT_CYC = `TMS_LOCKOUT_MS * `TMS_CYC_PER_MS,
	parameter AVG_CYC = `TMS_AVG_MS * `TMS_CYC_PER_MS
) (
	input wire clock_in, // 200 MHz clock
	input wire reset_n_in, // asynchronous reset, active low
	input wire [7:0] addr_in, // register byte address
	input wire [31:0] wdata_in, // write data
	input wire wr_in, // write strobe
	input wire rd_in, // read strobe
	output reg [31:0] rdata_out, // read data, cycle after read strobe
	input wire pulse_n_in, // tipping bucket pin, low is a pulse
	input wire adc_valid_in, // conversion ready
	input wire [13:0] adc_data_in, // conversion result
	input wire bus_done_in, // bus measurement result ready
	input wire dur_valid_in, // duration reply seen
	input wire [CHW-1:0] dur_ch_in, // channel of duration reply
	input wire [15:0] dur_s_in, // reported duration in seconds
	input wire snoop_valid_in, // result captured from another recorder
	input wire [CHW-1:0] snoop_ch_in, // channel of captured result
	input wire [31:0] snoop_data_in, // captured result
	output reg [NCH-1:0] meas_start_out, // one-cycle start per channel
	output reg bus_cmd_valid_out, // issue a bus command
	output reg [2:0] bus_cmd_kind_out, // command kind
	output reg [CHW-1:0] bus_cmd_ch_out, // command channel
	output reg bus_oe_n_out, // bus drive enable, low drives
	output reg adc_busy_out, // averaging window open
	output reg sync_req_out, // one-cycle clock correction request
	output reg tx_start_out, // one-cycle transmit start
	output reg [NCH-1:0] tx_mask_out // channels in this transmission
);
	localparam S_IDLE = 2'h0;
	localparam S_AVG = 2'h1;
	localparam S_DIV = 2'h2;
	localparam S_FIN = 2'h3;
	reg [31:0] ctrl_reg, slot_start_reg, slot_dur_reg, frame_dur_reg, guard_reg;
	reg [31:0] slope_reg, offs_reg, incr_reg, accum_reg, raw_reg, fin_reg, snoop_reg;
	reg [31:0] ch_cfg_reg [0:NCH-1];
	reg [31:0] ch_dur_reg [0:NCH-1];
	reg [31:0] cyc_reg, ms_reg, age_reg, try_reg, lock_reg, win_reg;
	reg [15:0] frame_reg;
	reg ms_tick, synced_reg, m_busy_reg;
	reg [15:0] lfsr_reg;
	reg [NCH-1:0] pend_reg, new_reg, txp_reg;
	reg [1:0] state_reg;
	reg [CHW-1:0] adc_ch_reg;
	reg [47:0] sum_reg;
	reg [31:0] cnt_reg, avg_reg;
	reg p_s1, p_s2, p_prev;
	wire en = ctrl_reg[`TMS_B_EN];
	wire listen = ctrl_reg[`TMS_B_LISTEN];
	wire lfsr_fb = lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10];
	// drift window in ms: guard / drift = guard * 500000 at 2 ppm
	wire [63:0] win_full = {32'h0, guard_reg} * (64'd1000000 / `TMS_DRIFT_PPM);
	wire [31:0] age_lim = win_full[31:0];
	wire [31:0] try_lim = age_lim / `TMS_SYNC_TRIES;
	wire random_mode = !synced_reg || (age_reg >= age_lim);
	wire frame_end = ms_tick && (ms_reg >= frame_dur_reg - 32'h1);
	// transmit point, randomised inside the padded slot when time is doubtful
	wire [31:0] span = slot_dur_reg - (guard_reg << 1);
	wire [31:0] rnd = (span == 32'h0) ? 32'h0 : {16'h0, lfsr_reg} % span;
	wire [31:0] tx_ms = slot_start_reg + guard_reg + (random_mode ? rnd : 32'h0);
	wire [NCH-1:0] rd_due, tx_due, st_hit;
	wire [NCH-1:0] is_adc, is_m, is_c, is_r;

	// per channel schedule: due test and start moment
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : g_ch
			wire [7:0] r_int = ch_cfg_reg[g][7:0];
			wire [7:0] t_int = ch_cfg_reg[g][15:8];
			wire [7:0] t_off = ch_cfg_reg[g][23:16];
			wire [2:0] kind = ch_cfg_reg[g][26:24];
			wire [31:0] dur = (kind == `TMS_K_CMD_R) ? 32'h0 : ch_dur_reg[g];
			wire long_m = dur > frame_dur_reg;
			wire [31:0] dmod = (frame_dur_reg == 32'h0) ? 32'h0 : dur % frame_dur_reg;
			// finish near frame end for long ones, else just ahead of the slot
			wire [31:0] base = long_m ? frame_dur_reg :
				slot_start_reg - guard_reg - `TMS_MARGIN_MS;
			wire wrap = dmod > base; // start falls in the previous frame
			wire [31:0] st0 = base + frame_dur_reg - dmod;
			wire [31:0] st_ms = (st0 >= frame_dur_reg) ? st0 - frame_dur_reg : st0;
			wire [15:0] fr = frame_reg + {15'h0, wrap};
			wire [15:0] rel_r = fr - {8'h0, t_off};
			// the set is latched at the wrap, so it is judged for the frame about to begin
			wire [15:0] rel_t = frame_reg + 16'h1 - {8'h0, t_off};
			assign rd_due[g] = (r_int != 8'h0) && (rel_r % {8'h0, r_int} == 16'h0);
			assign tx_due[g] = (t_int != 8'h0) && (rel_t % {8'h0, t_int} == 16'h0);
			assign st_hit[g] = ms_tick && (ms_reg == st_ms);
			assign is_adc[g] = (kind == `TMS_K_VOLT) || (kind == `TMS_K_CURR);
			assign is_m[g] = kind == `TMS_K_CMD_M;
			assign is_c[g] = kind == `TMS_K_CMD_C;
			assign is_r[g] = kind == `TMS_K_CMD_R;
		end
	endgenerate

	// arbiter: lowest pending channel whose resource is free
	reg [NCH-1:0] grant;
	reg found;
	integer i;
	always @* begin
		grant = {NCH{1'b0}};
		found = 1'b0;
		for (i = 0; i < NCH; i = i + 1) begin
			if (!found && pend_reg[i]) begin
				if ((is_adc[i] && state_reg == S_IDLE) ||
					(is_m[i] && !m_busy_reg) ||
					(is_c[i] && !m_busy_reg) ||
					(is_r[i] && !m_busy_reg)) begin
					grant[i] = 1'b1;
					found = 1'b1;
				end
			end
		end
	end
	reg [CHW-1:0] gch;
	always @* begin
		gch = {CHW{1'b0}};
		for (i = NCH - 1; i >= 0; i = i - 1) begin
			if (grant[i]) begin
				gch = i[CHW-1:0];
			end
		end
	end
	wire g_bus = found && !is_adc[gch];

	// front end arithmetic: millivolts, loop current in microamps, finished value
	wire [63:0] mv_p = {32'h0, avg_reg} * `TMS_FULL_MV;
	wire [31:0] mv = mv_p[31:0] / `TMS_ADC_MAX;
	wire is_cur = ch_cfg_reg[adc_ch_reg][26:24] == `TMS_K_CURR;
	// ua = mv / 250 ohm * 1000; no clamp below 4 mA so a broken loop shows up downstream
	wire [31:0] ua = mv * (32'd1000 / `TMS_SENSE_OHM);
	wire [31:0] raw = is_cur ? ua : mv;
	wire signed [63:0] prod = $signed({32'h0, raw_reg}) * $signed({{32{slope_reg[31]}}, slope_reg});
	wire signed [31:0] scaled = prod[47:16] + offs_reg;
	wire sat_hi = (scaled > $signed(32'h00007fff));
	wire sat_lo = (scaled < $signed(32'hffff8000));
	wire [31:0] fin16 = sat_hi ? 32'h00007fff : (sat_lo ? 32'hffff8000 : scaled);

	// time base, frame counter and clock-correction age
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cyc_reg <= 32'h0;
			ms_tick <= 1'b0;
			ms_reg <= 32'h0;
			frame_reg <= 16'h0;
			age_reg <= 32'h0;
			try_reg <= 32'h0;
			synced_reg <= 1'b0;
			sync_req_out <= 1'b0;
			lfsr_reg <= 16'hace1;
		end else begin
			ms_tick <= (cyc_reg == CYC_PER_MS - 1);
			cyc_reg <= (cyc_reg == CYC_PER_MS - 1) ? 32'h0 : cyc_reg + 32'h1;
			lfsr_reg <= {lfsr_reg[14:0], lfsr_fb};
			sync_req_out <= 1'b0;
			if (wr_in && addr_in == `TMS_A_MS_IN_FRAME) begin
				ms_reg <= wdata_in; // corrected time from the reference
				age_reg <= 32'h0;
				try_reg <= 32'h0;
				synced_reg <= 1'b1;
			end else if (ms_tick) begin
				ms_reg <= frame_end ? 32'h0 : ms_reg + 32'h1;
				if (age_reg != 32'hffffffff) begin
					age_reg <= age_reg + 32'h1;
				end
				// several attempts inside each drift window
				if (try_reg + 32'h1 >= try_lim) begin
					try_reg <= 32'h0;
					sync_req_out <= 1'b1;
				end else begin
					try_reg <= try_reg + 32'h1;
				end
			end
			if (wr_in && addr_in == `TMS_A_FRAME_CNT) begin
				frame_reg <= wdata_in[15:0];
			end else if (frame_end) begin
				frame_reg <= frame_reg + 16'h1;
			end
		end
	end

	// pulse input: two-stage synchroniser, falling edge, lockout, accumulate
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			p_s1 <= 1'b1;
			p_s2 <= 1'b1;
			p_prev <= 1'b1;
			lock_reg <= 32'h0;
			accum_reg <= 32'h0;
		end else begin
			p_s1 <= pulse_n_in;
			p_s2 <= p_s1;
			p_prev <= p_s2;
			if (lock_reg != 32'h0) begin
				lock_reg <= lock_reg - 32'h1;
			end else if (p_prev && !p_s2) begin
				lock_reg <= LOCKOUT_CYC - 1;
				// accumulator is 16.16; integer increments land in the upper half
				accum_reg <= accum_reg + (ctrl_reg[`TMS_B_INC_FRAC] ? incr_reg :
					{incr_reg[15:0], 16'h0});
			end
			if (wr_in && addr_in == `TMS_A_ACCUM) begin
				accum_reg <= wdata_in;
			end
		end
	end

	// scheduling, command issue, averaging and transmit
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pend_reg <= {NCH{1'b0}};
			new_reg <= {NCH{1'b0}};
			txp_reg <= {NCH{1'b0}};
			m_busy_reg <= 1'b0;
			meas_start_out <= {NCH{1'b0}};
			bus_cmd_valid_out <= 1'b0;
			bus_cmd_kind_out <= 3'h0;
			bus_cmd_ch_out <= {CHW{1'b0}};
			bus_oe_n_out <= 1'b1;
			adc_busy_out <= 1'b0;
			tx_start_out <= 1'b0;
			tx_mask_out <= {NCH{1'b0}};
			state_reg <= S_IDLE;
			adc_ch_reg <= {CHW{1'b0}};
			sum_reg <= 48'h0;
			cnt_reg <= 32'h0;
			avg_reg <= 32'h0;
			win_reg <= 32'h0;
			raw_reg <= 32'h0;
			fin_reg <= 32'h0;
			snoop_reg <= 32'h0;
		end else begin
			meas_start_out <= grant;
			bus_cmd_valid_out <= g_bus && !listen;
			bus_cmd_kind_out <= ch_cfg_reg[gch][26:24];
			bus_cmd_ch_out <= gch;
			bus_oe_n_out <= !(g_bus && !listen);
			tx_start_out <= 1'b0;
			// schedule reads; in listen mode the bus channels are not polled
			pend_reg <= (pend_reg & ~grant) | (en ? (st_hit & rd_due & ~(tx_due & 0) &
				~(is_m | is_c | is_r) & ~{NCH{1'b0}}) : {NCH{1'b0}}) |
				((en && !listen) ? (st_hit & rd_due & (is_m | is_c | is_r)) : {NCH{1'b0}});
			if (found && is_m[gch] && !listen) begin
				m_busy_reg <= 1'b1;
			end else if (bus_done_in) begin
				m_busy_reg <= 1'b0;
			end
			// latch the transmit set at frame start; listen mode needs new data
			if (frame_end) begin
				txp_reg <= en ? tx_due : {NCH{1'b0}};
			end
			if (en && ms_tick && ms_reg == tx_ms && !frame_end) begin
				tx_mask_out <= txp_reg & (listen ? new_reg : {NCH{1'b1}});
				tx_start_out <= |(txp_reg & (listen ? new_reg : {NCH{1'b1}}));
				txp_reg <= {NCH{1'b0}};
			end
			// capture wins over the clear in the same cycle
			for (i = 0; i < NCH; i = i + 1) begin
				if (snoop_valid_in && listen && snoop_ch_in == i[CHW-1:0]) begin
					new_reg[i] <= 1'b1;
				end else if (tx_start_out && tx_mask_out[i]) begin
					new_reg[i] <= 1'b0;
				end
			end
			if (snoop_valid_in && listen) begin
				snoop_reg <= snoop_data_in;
			end
			case (state_reg)
				S_IDLE: begin
					if (found && is_adc[gch]) begin
						adc_ch_reg <= gch;
						sum_reg <= 48'h0;
						cnt_reg <= 32'h0;
						win_reg <= AVG_CYC - 1;
						adc_busy_out <= 1'b1;
						state_reg <= S_AVG;
					end
				end
				S_AVG: begin
					if (adc_valid_in) begin
						sum_reg <= sum_reg + {34'h0, adc_data_in};
						cnt_reg <= cnt_reg + 32'h1;
					end
					if (win_reg == 32'h0) begin
						adc_busy_out <= 1'b0;
						state_reg <= S_DIV;
					end else begin
						win_reg <= win_reg - 32'h1;
					end
				end
				S_DIV: begin
					avg_reg <= (cnt_reg == 32'h0) ? 32'h0 : sum_reg[31:0] / cnt_reg;
					state_reg <= S_FIN;
				end
				S_FIN: begin
					raw_reg <= raw;
					state_reg <= S_IDLE;
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
			fin_reg <= ctrl_reg[`TMS_B_DTYPE16] ? fin16 : scaled;
		end
	end

	// register writes and learned durations
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctrl_reg <= 32'h0;
			slot_start_reg <= 32'h0;
			slot_dur_reg <= `TMS_R_SLOT_DUR;
			frame_dur_reg <= `TMS_R_FRAME_DUR;
			guard_reg <= `TMS_R_GUARD;
			slope_reg <= `TMS_R_SLOPE;
			offs_reg <= 32'h0;
			incr_reg <= `TMS_R_INCR;
			for (i = 0; i < NCH; i = i + 1) begin
				ch_cfg_reg[i] <= 32'h0;
				ch_dur_reg[i] <= 32'h0;
			end
		end else begin
			if (wr_in) begin
				case (addr_in)
					`TMS_A_CTRL: ctrl_reg <= wdata_in;
					`TMS_A_SLOT_START: slot_start_reg <= wdata_in;
					`TMS_A_SLOT_DUR: slot_dur_reg <= wdata_in;
					`TMS_A_FRAME_DUR: frame_dur_reg <= wdata_in;
					`TMS_A_GUARD: guard_reg <= wdata_in;
					`TMS_A_SLOPE: slope_reg <= wdata_in;
					`TMS_A_OFFS: offs_reg <= wdata_in;
					`TMS_A_INCR: incr_reg <= wdata_in;
					default: begin
					end
				endcase
				for (i = 0; i < NCH; i = i + 1) begin
					if (addr_in == `TMS_A_CH_BASE + i[4:0] * 8'h08) begin
						ch_cfg_reg[i] <= wdata_in;
					end
					if (addr_in == `TMS_A_CH_BASE + i[4:0] * 8'h08 + 8'h04) begin
						ch_dur_reg[i] <= wdata_in;
					end
				end
			end
			// learned duration overrides a same-cycle software write
			if (dur_valid_in && ctrl_reg[`TMS_B_LEARN]) begin
				ch_dur_reg[dur_ch_in] <= {16'h0, dur_s_in} * 32'd1000;
			end
		end
	end

	// read port, data one cycle after the strobe; unmapped reads as zero
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_out <= 32'h0;
		end else if (rd_in) begin
			rdata_out <= 32'h0;
			case (addr_in)
				`TMS_A_CTRL: rdata_out <= ctrl_reg;
				`TMS_A_SLOT_START: rdata_out <= slot_start_reg;
				`TMS_A_SLOT_DUR: rdata_out <= slot_dur_reg;
				`TMS_A_FRAME_DUR: rdata_out <= frame_dur_reg;
				`TMS_A_GUARD: rdata_out <= guard_reg;
				`TMS_A_STATUS: rdata_out <= {{(24-NCH){1'b0}}, new_reg, 4'h0,
					synced_reg, adc_busy_out, m_busy_reg, random_mode};
				`TMS_A_FRAME_CNT: rdata_out <= {16'h0, frame_reg};
				`TMS_A_MS_IN_FRAME: rdata_out <= ms_reg;
				`TMS_A_ACCUM: rdata_out <= accum_reg;
				`TMS_A_RAW: rdata_out <= raw_reg;
				`TMS_A_FIN: rdata_out <= fin_reg;
				`TMS_A_SLOPE: rdata_out <= slope_reg;
				`TMS_A_OFFS: rdata_out <= offs_reg;
				`TMS_A_INCR: rdata_out <= incr_reg;
				`TMS_A_SNOOP: rdata_out <= snoop_reg;
				default: begin
				end
			endcase
			for (i = 0; i < NCH; i = i + 1) begin
				if (addr_in == `TMS_A_CH_BASE + i[4:0] * 8'h08) begin
					rdata_out <= ch_cfg_reg[i];
				end
				if (addr_in == `TMS_A_CH_BASE + i[4:0] * 8'h08 + 8'h04) begin
					rdata_out <= ch_dur_reg[i];
				end
			end
		end
	end
endmodule

// >>> test/tms_asserts.sv
// port-level assertion checker for the frame scheduler
`timescale 1ns/1ps
module tms_checker #(
	parameter NCH = 4,
	parameter AVG_CYC = 20
) (
	input wire clock_in, // clock
	input wire reset_n_in, // reset, active low
	input wire [7:0] addr_in, // register address
	input wire [31:0] wdata_in, // write data
	input wire wr_in, // write strobe
	input wire bus_done_in, // M result ready
	input wire [NCH-1:0] meas_start_out, // measurement starts
	input wire bus_cmd_valid_out, // bus command
	input wire [2:0] bus_cmd_kind_out, // command kind
	input wire bus_oe_n_out, // bus drive, low drives
	input wire adc_busy_out, // averaging window
	input wire tx_start_out, // transmit start
	input wire [NCH-1:0] tx_mask_out // transmit channels
);
	reg listen_reg; // listen bit as last written
	reg m_busy_reg; // M measurement outstanding
	reg [15:0] win_reg; // cycles of the open averaging window
	default clocking @(posedge clock_in);
	endclocking
	default disable iff (!reset_n_in);
	// shadow state; a control write lands a cycle late, so listen is trusted one cycle on
	always @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			listen_reg <= 1'b0;
			m_busy_reg <= 1'b0;
			win_reg <= 16'h0;
		end else begin
			if (wr_in && addr_in == 8'h00) begin
				listen_reg <= wdata_in[1];
			end
			if (bus_cmd_valid_out && bus_cmd_kind_out == 3'h3) begin
				m_busy_reg <= 1'b1;
			end else if (bus_done_in) begin
				m_busy_reg <= 1'b0;
			end
			win_reg <= adc_busy_out ? win_reg + 16'h1 : 16'h0;
		end
	end
	a_oe_with_cmd: assert property (bus_oe_n_out == !bus_cmd_valid_out)
		else $error("bus drive enable does not follow command");
	a_listen_quiet: assert property (listen_reg && $past(listen_reg) |->
		bus_oe_n_out && !bus_cmd_valid_out) else $error("bus driven in listen mode");
	a_m_holds_bus: assert property (m_busy_reg |-> !bus_cmd_valid_out)
		else $error("command issued while M measurement runs");
	a_cmd_kind_known: assert property (bus_cmd_valid_out |->
		bus_cmd_kind_out inside {3'h3, 3'h4, 3'h5}) else $error("unknown command kind");
	a_one_start: assert property ($onehot0(meas_start_out))
		else $error("two measurements started in one cycle");
	a_window_holds: assert property ($rose(adc_busy_out) |-> adc_busy_out[*8])
		else $error("averaging window closed early");
	a_window_len: assert property ($fell(adc_busy_out) |->
		win_reg >= AVG_CYC && win_reg <= AVG_CYC + 2) else $error("averaging window length");
	a_tx_single: assert property (tx_start_out |=> !tx_start_out)
		else $error("transmit start longer than one cycle");
	a_tx_has_mask: assert property (tx_start_out |-> tx_mask_out != 0)
		else $error("transmit start with empty channel set");
	c_m_cmd: cover property (bus_cmd_valid_out && bus_cmd_kind_out == 3'h3);
	c_tx: cover property (tx_start_out);
	c_window: cover property ($fell(adc_busy_out));
endmodule

// >>> test/tms_sensors.sv
// far side model: converter source, tipping bucket, bus sensors and another recorder
`timescale 1ns/1ps
module tms_sensors #(
	parameter M_WAIT = 100,
	parameter DUR_S = 1
) (
	input wire clock_in, // clock
	input wire adc_busy_in, // averaging window open
	input wire cmd_valid_in, // bus command
	input wire [2:0] cmd_kind_in, // command kind
	input wire [1:0] cmd_ch_in, // command channel
	output logic pulse_n_out = 1'b1, // bucket pin, pulled up
	output logic adc_valid_out = 1'b0, // sample strobe
	output logic [13:0] adc_data_out = 14'h0, // sample
	output logic done_out = 1'b0, // M result ready
	output logic dur_valid_out = 1'b0, // duration reply
	output logic [1:0] dur_ch_out = 2'h0, // reply channel
	output logic [15:0] dur_s_out = 16'h0, // reply seconds
	output logic snp_valid_out = 1'b0, // result seen from other recorder
	output logic [1:0] snp_ch_out = 2'h0, // its channel
	output logic [31:0] snp_data_out = 32'h0 // its data
);
	logic [13:0] level = 14'h0; // input level set by the bench
	int wait_cnt = 0; // cycles left of the M measurement
	// converter gives a steady level so the average is exact
	always @(posedge clock_in) begin
		adc_valid_out <= adc_busy_in;
		adc_data_out <= level;
	end
	// bus sensor replies with its duration at once, result after M_WAIT cycles
	always @(posedge clock_in) begin
		dur_valid_out <= cmd_valid_in && cmd_kind_in == 3'h3;
		dur_ch_out <= cmd_ch_in;
		dur_s_out <= (cmd_valid_in && cmd_kind_in == 3'h3) ? 16'(DUR_S) : ~dur_s_out;
		done_out <= wait_cnt == 1;
		if (cmd_valid_in && cmd_kind_in == 3'h3) wait_cnt <= M_WAIT;
		else if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
	end
	// switch closure pulls the pin low, release lets the pull-up win
	task tip(input int n);
		pulse_n_out <= 1'b0;
		repeat (n) @(posedge clock_in);
		pulse_n_out <= 1'b1;
	endtask
	// another recorder's result; data line scrambled once it is gone
	task snoop(input logic [1:0] ch, input logic [31:0] v);
		snp_ch_out <= ch;
		snp_data_out <= v;
		snp_valid_out <= 1'b1;
		@(posedge clock_in);
		snp_valid_out <= 1'b0;
		snp_data_out <= ~v;
	endtask
endmodule

// >>> test/tms_bench.sv
// self-checking bench for the frame scheduler
`timescale 1ns/1ps
`include "tms_regs.vh"
module tms_bench;
	typedef struct {logic [2:0] kind; logic [13:0] smp; logic [31:0] slope; logic [31:0] offs;} tms_row_t;
	logic clock_in, reset_n_in, wr_in, rd_in, pulse_n_in, adc_valid_in, bus_done_in;
	logic dur_valid_in, snoop_valid_in, bus_cmd_valid_out, bus_oe_n_out, adc_busy_out, tx_start_out;
	logic sync_req_out;
	int n_sync = 0;
	logic [7:0] addr_in;
	logic [31:0] wdata_in, rdata_out, snoop_data_in, d;
	logic [13:0] adc_data_in;
	logic [1:0] dur_ch_in, snoop_ch_in, bus_cmd_ch_out;
	logic [15:0] dur_s_in;
	logic [3:0] meas_start_out, tx_mask_out;
	logic [2:0] bus_cmd_kind_out;
	logic [7:0] kinds = 8'h0;
	logic [3:0] tx_mask = 4'h0;
	logic [7:0] ra [7] = '{8'h08, 8'h0c, 8'h10, 8'h2c, 8'h34, 8'h14, 8'h3c};
	logic [31:0] rv [7] = '{`TMS_R_SLOT_DUR, `TMS_R_FRAME_DUR, `TMS_R_GUARD, `TMS_R_SLOPE,
		`TMS_R_INCR, 32'h1, 32'h0};
	tms_row_t rows [5];
	int fails = 0;
	int cmp_count = 0;
	int n_start = 0;
	int n_cmd = 0;
	int n_tx = 0;
	int n0, t0, i;
	longint e;
	tms_top #(.CYC_PER_MS(10), .LOCKOUT_CYC(50), .AVG_CYC(20)) dut_u (.clock_in, .reset_n_in,
		.addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .pulse_n_in, .adc_valid_in, .adc_data_in,
		.bus_done_in, .dur_valid_in, .dur_ch_in, .dur_s_in, .snoop_valid_in, .snoop_ch_in,
		.snoop_data_in, .meas_start_out, .bus_cmd_valid_out, .bus_cmd_kind_out, .bus_cmd_ch_out,
		.bus_oe_n_out, .adc_busy_out, .sync_req_out, .tx_start_out, .tx_mask_out);
	tms_sensors sens_u (.clock_in, .adc_busy_in(adc_busy_out), .cmd_valid_in(bus_cmd_valid_out),
		.cmd_kind_in(bus_cmd_kind_out), .cmd_ch_in(bus_cmd_ch_out), .pulse_n_out(pulse_n_in),
		.adc_valid_out(adc_valid_in), .adc_data_out(adc_data_in), .done_out(bus_done_in),
		.dur_valid_out(dur_valid_in), .dur_ch_out(dur_ch_in), .dur_s_out(dur_s_in),
		.snp_valid_out(snoop_valid_in), .snp_ch_out(snoop_ch_in), .snp_data_out(snoop_data_in));
	// 200 MHz clock
	initial begin
		clock_in = 1'b0;
		forever #2.5 clock_in = ~clock_in;
	end
	// event counters, sampled mid-cycle where the registered outputs have settled
	always @(negedge clock_in) begin
		if (meas_start_out[0]) n_start++;
		if (bus_cmd_valid_out) n_cmd++;
		if (bus_cmd_valid_out) kinds[bus_cmd_kind_out] = 1'b1;
		if (tx_start_out) n_tx++;
		if (sync_req_out) n_sync++;
		if (tx_start_out) tx_mask = tx_mask_out;
	end
	task cyc(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	task wrr(input logic [7:0] a, input logic [31:0] v);
		addr_in <= a;
		wdata_in <= v;
		wr_in <= 1'b1;
		@(posedge clock_in);
		wr_in <= 1'b0;
		@(posedge clock_in);
	endtask
	// read data appear in the cycle after the strobe and hold until the next read
	task rdr(input logic [7:0] a, output logic [31:0] v);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1 v = rdata_out;
		@(posedge clock_in);
	endtask
	task chk(input string nm, input logic [31:0] x, input logic [31:0] v);
		cmp_count++;
		if (v !== x) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, x, v);
		end
	endtask
	task rchk(input string nm, input logic [7:0] a, input logic [31:0] x);
		logic [31:0] v;
		rdr(a, v);
		chk(nm, x, v);
	endtask
	// jump near the frame end, wrap, then run through the transmit point at 1525 ms
	task frame_to_tx;
		wrr(`TMS_A_MS_IN_FRAME, 32'h7c6);
		cyc(120);
		wrr(`TMS_A_MS_IN_FRAME, 32'h5f0);
		cyc(80);
	endtask
	task give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// hang guard, well beyond the roughly 7400 cycles the tests need
	initial begin
		#100000;
		fails++;
		$display("[ERR] watchdog expected finish seen hang");
		give_verdict;
	end
	// main sequence
	initial begin
		reset_n_in = 1'b0;
		addr_in = 8'h0;
		wdata_in = 32'h0;
		wr_in = 1'b0;
		rd_in = 1'b0;
		rows[0] = '{`TMS_K_VOLT, 14'h3fff, 32'h10000, 32'h0};
		rows[1] = '{`TMS_K_VOLT, 14'h0, 32'h20000, 32'h7};
		rows[2] = '{`TMS_K_VOLT, 14'h2000, 32'h8000, 32'h0};
		rows[3] = '{`TMS_K_CURR, 14'h3fff, 32'h10000, 32'h0};
		rows[4] = '{`TMS_K_CURR, 14'hccc, 32'h10000, 32'h4};
		repeat (2) @(posedge clock_in);
		reset_n_in <= 1'b1;
		@(posedge clock_in);
		wrr(`TMS_A_STATUS, 32'hffffffff);
		wrr(8'h3c, 32'hffffffff);
		for (i = 0; i < 7; i++) rchk("reset value", ra[i], rv[i]);
		$display("reset values done");
		wrr(`TMS_A_FRAME_DUR, 32'h7d0);
		wrr(`TMS_A_SLOT_START, 32'h5dc);
		wrr(`TMS_A_CTRL, 32'h1);
		// table: measurement starts 5 ms after the jump to 470 ms
		for (i = 0; i < 5; i++) begin
			wrr(`TMS_A_SLOPE, rows[i].slope);
			wrr(`TMS_A_OFFS, rows[i].offs);
			wrr(`TMS_A_CH_BASE, {5'h0, rows[i].kind, 24'h000101});
			sens_u.level <= rows[i].smp;
			n0 = n_start;
			wrr(`TMS_A_MS_IN_FRAME, 32'h1d6);
			cyc(150);
			chk("start", 32'(n0 + 1), 32'(n_start));
			e = longint'(rows[i].smp) * 5000 / 16383;
			if (rows[i].kind == `TMS_K_CURR) e = e * 4;
			if (rows[i].kind == `TMS_K_CURR) rchk("raw current", `TMS_A_RAW, 32'(e));
			else rchk("raw volt", `TMS_A_RAW, 32'(e));
			rchk("finished", `TMS_A_FIN, 32'(((e * rows[i].slope) >> 16) + rows[i].offs));
			$display("row %0d done", i);
		end
		// transmit interval 2 with offset 1: due in frame 1, not in frame 2
		wrr(`TMS_A_CH_BASE, 32'h00010201);
		wrr(`TMS_A_FRAME_CNT, 32'h0);
		t0 = n_tx;
		frame_to_tx;
		chk("tx in due frame", 32'(t0 + 1), 32'(n_tx));
		chk("tx mask", 32'h1, {28'h0, tx_mask});
		frame_to_tx;
		chk("tx in idle frame", 32'(t0 + 1), 32'(n_tx));
		$display("interval test done");
		// tips: second inside the lockout is ignored, then a fractional increment
		wrr(`TMS_A_ACCUM, 32'h0);
		sens_u.tip(4);
		cyc(10);
		sens_u.tip(4);
		cyc(60);
		rchk("accum one tip", `TMS_A_ACCUM, 32'h10000);
		sens_u.tip(4);
		cyc(10);
		rchk("accum integer", `TMS_A_ACCUM, 32'h20000);
		wrr(`TMS_A_CTRL, 32'h9);
		wrr(`TMS_A_INCR, 32'h8000);
		cyc(60);
		sens_u.tip(4);
		cyc(10);
		rchk("accum fraction", `TMS_A_ACCUM, 32'h28000);
		$display("pulse test done");
		// M on ch1 holds C on ch2 and R on ch3 until its result
		wrr(`TMS_A_CTRL, 32'h5);
		wrr(8'h40, 32'h0);
		wrr(8'h48, 32'h03010101);
		wrr(8'h50, 32'h04010101);
		wrr(8'h58, 32'h05010101);
		n0 = n_cmd;
		kinds = 8'h0;
		wrr(`TMS_A_MS_IN_FRAME, 32'h1d6);
		cyc(120);
		chk("cmds while M busy", 32'(n0 + 1), 32'(n_cmd));
		cyc(200);
		chk("cmds after result", 32'(n0 + 3), 32'(n_cmd));
		chk("kinds issued", 32'h38, {24'h0, kinds});
		rchk("learned duration", 8'h4c, 32'h3e8);
		$display("bus test done");
		// listen: report only after a captured result
		wrr(8'h48, 32'h0);
		wrr(8'h50, 32'h0);
		wrr(8'h58, 32'h0);
		wrr(8'h40, 32'h03010101);
		wrr(`TMS_A_CTRL, 32'h3);
		n0 = n_cmd;
		t0 = n_tx;
		frame_to_tx;
		chk("tx without new data", 32'(t0), 32'(n_tx));
		sens_u.snoop(2'h0, 32'h1234abcd);
		rchk("captured data", `TMS_A_SNOOP, 32'h1234abcd);
		rdr(`TMS_A_STATUS, d);
		chk("new data flag", 32'h1, {31'h0, d[8]});
		frame_to_tx;
		chk("tx with new data", 32'(t0 + 1), 32'(n_tx));
		chk("listen tx mask", 32'h1, {28'h0, tx_mask});
		frame_to_tx;
		chk("tx after report", 32'(t0 + 1), 32'(n_tx));
		chk("listen commands", 32'(n0), 32'(n_cmd));
		$display("listen test done");
		// second reset: unsynced clock means random mode, measurements still run
		reset_n_in <= 1'b0;
		cyc(2);
		reset_n_in <= 1'b1;
		cyc(1);
		rdr(`TMS_A_STATUS, d);
		chk("random mode", 32'h1, {31'h0, d[0]});
		wrr(`TMS_A_FRAME_DUR, 32'h7d0);
		wrr(`TMS_A_SLOT_START, 32'h5dc);
		wrr(`TMS_A_CH_BASE, 32'h00010101);
		wrr(`TMS_A_CTRL, 32'h1);
		n0 = n_start;
		n_sync = 0;
		cyc(5000);
		chk("no early sync request", 32'h0, 32'(n_sync));
		chk("start in random mode", 32'(n0 + 1), 32'(n_start));
		rdr(`TMS_A_STATUS, d);
		chk("still random", 32'h1, {31'h0, d[0]});
		$display("random mode test done");
		give_verdict;
	end
endmodule
bind tms_top tms_checker #(.NCH(NCH), .AVG_CYC(AVG_CYC)) chk_u (.clock_in, .reset_n_in, .addr_in,
	.wdata_in, .wr_in, .bus_done_in, .meas_start_out, .bus_cmd_valid_out, .bus_cmd_kind_out,
	.bus_oe_n_out, .adc_busy_out, .tx_start_out, .tx_mask_out);
